// ==== hw/analog_remote_interface_ctrl.sv ====
// control logic behind the isolated analog remote-control port
`timescale 1ns/1ps
`default_nettype none
module analog_remote_interface_ctrl
  import arc_pkg::*;
#(
  parameter int unsigned TICK_CYC  = TICK_CYCLES,
  parameter int unsigned ACK_TICKS = ACK_LOW_TICKS,
  parameter int unsigned RDY_TICKS = START_TICKS
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // port pins and converter codes
  input  wire logic        takeover_n_pin,
  input  wire logic        res_mode_n_pin,
  input  wire logic        input_standby_ctrl,
  input  wire logic [15:0] voltage_setpoint_in,
  input  wire logic [15:0] current_setpoint_in,
  input  wire logic [15:0] power_setpoint_in,
  input  wire logic [15:0] resistance_setpoint_in,
  // device core
  input  wire logic        overtemperature_alarm,
  input  wire logic        supply_failure_alarm,
  input  wire logic        overvoltage_alarm,
  input  wire logic        overcurrent_alarm,
  input  wire logic        overpower_alarm,
  input  wire logic [15:0] actual_voltage,
  input  wire logic [15:0] actual_current,
  input  wire logic        manual_dc_on,
  // results
  output logic      [15:0] set_voltage,
  output logic      [15:0] set_current,
  output logic      [15:0] set_power,
  output logic      [15:0] set_resistance,
  output logic      [15:0] voltage_monitor_out,
  output logic      [15:0] current_monitor_out,
  output logic             analog_active,
  output logic             resistance_mode,
  output logic             dc_input_on,
  output logic             alarm1_out,
  output logic             alarm2_out,
  output logic             device_ready,
  output logic             irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // set value in 10 V steps; 5 V codes are clipped then doubled
  function automatic logic [15:0] quant(input logic [15:0] raw,
                                        input logic        r5);
    logic [15:0] full;
    logic [15:0] c;
    full = r5 ? STEPS_5V : STEPS_10V;
    c    = (raw > full) ? full : raw;
    return r5 ? {c[14:0], 1'b0} : c;
  endfunction : quant

  // monitor code for a 0..26214 actual value
  function automatic logic [15:0] mon(input logic [15:0] act,
                                      input logic        r5);
    logic [15:0] c;
    c = (act > STEPS_10V) ? STEPS_10V : act;
    return r5 ? {1'b0, c[15:1]} : c;
  endfunction : mon

  // ---------------------------------------------------------------
  // acquisition parts
  // ---------------------------------------------------------------
  acq_if #(.W(PIN_W)) acq ();

  tick_gen #(.CYCLES(TICK_CYC)) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .acq     (acq)
  );

  pin_sync #(.W(PIN_W)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in ({resistance_setpoint_in, power_setpoint_in,
                current_setpoint_in, voltage_setpoint_in,
                input_standby_ctrl, res_mode_n_pin,
                takeover_n_pin}),
    .acq      (acq)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  ctrl;
    logic [4:0]  route;
    logic [3:0]  irq_st;
    logic [3:0]  irq_mk;
    logic [31:0] rdata;
    logic        eval;
    logic        s_rem_n;
    logic        s_res_n;
    logic        s_sb;
    logic [15:0] s_v;
    logic [15:0] s_i;
    logic [15:0] s_p;
    logic [15:0] s_r;
    ctrl_mode_t  mode;
    logic [7:0]  low_cnt;
    logic [7:0]  rdy_cnt;
    logic        ready;
    logic [4:0]  latch;
    logic [15:0] set_v;
    logic [15:0] set_i;
    logic [15:0] set_p;
    logic [15:0] set_r;
    logic [15:0] mon_v;
    logic [15:0] mon_i;
    logic        res_on;
    logic        dc_on;
    logic        al1;
    logic        al2;
    logic        irq;
  } ctrl_st_t;

  ctrl_st_t q;
  ctrl_st_t d;

  localparam logic [7:0] ACK_MIN = 8'(ACK_TICKS);
  localparam logic [7:0] RDY_MAX = 8'(RDY_TICKS);

  logic [4:0] alm;
  assign alm = {overpower_alarm, overcurrent_alarm, overvoltage_alarm,
                supply_failure_alarm, overtemperature_alarm};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       sb_on;
    logic       take;
    logic       dig;
    logic       r5;
    logic       ack;
    logic [3:0] ev;
    logic [3:0] w1c;
    logic       steady;
    sb_on = 1'b0;
    steady = 1'b0;
    take  = 1'b0;
    dig   = 1'b0;
    r5    = 1'b0;
    ack   = 1'b0;
    ev    = '0;
    w1c   = '0;
    d     = q;
    if (clk_en) begin
      r5  = q.ctrl[CTRL_RANGE5];
      dig = q.ctrl[CTRL_DIGREQ];

      // register port: writes
      if (reg_wr) begin
        unique case (reg_addr)
          REG_CTRL:   d.ctrl   = reg_wdata[2:0];
          REG_ROUTE:  d.route  = reg_wdata[4:0];
          REG_IRQ_ST: w1c      = reg_wdata[3:0];
          REG_IRQ_MK: d.irq_mk = reg_wdata[3:0];
          default: ;
        endcase
      end

      // register port: read data valid in the next cycle only
      d.rdata = '0;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_CTRL:   d.rdata = {29'h0, q.ctrl};
          REG_ROUTE:  d.rdata = {27'h0, q.route};
          REG_STATE:  d.rdata = {16'h0, 3'h0, q.latch, q.dc_on,
                                 q.res_on, q.ready, 2'h0, q.mode};
          REG_IRQ_ST: d.rdata = {28'h0, q.irq_st};
          REG_IRQ_MK: d.rdata = {28'h0, q.irq_mk};
          REG_SET_VI: d.rdata = {q.set_i, q.set_v};
          REG_SET_PR: d.rdata = {q.set_r, q.set_p};
          REG_MON:    d.rdata = {q.mon_i, q.mon_v};
          default:    d.rdata = '0;
        endcase
      end

      // capture pins only on the tick; evaluate one cycle later
      d.eval = acq.tick;
      if (acq.tick) begin
        d.s_rem_n = acq.pins[PIN_REM_N];
        d.s_res_n = acq.pins[PIN_RES_N];
        d.s_sb    = acq.pins[PIN_SB];
        d.s_v     = acq.pins[PIN_VSET +: 16];
        d.s_i     = acq.pins[PIN_ISET +: 16];
        d.s_p     = acq.pins[PIN_PSET +: 16];
        d.s_r     = acq.pins[PIN_RSET +: 16];
      end

      if (q.eval) begin
        take  = !q.s_rem_n;
        // polarity setting inverts the standby meaning
        sb_on = q.s_sb ^ q.ctrl[CTRL_SBINV];
        // a code torn mid-change differs a cycle later; skip that sample
        steady = (acq.pins[PIN_VSET +: 64] == {q.s_r, q.s_p, q.s_i, q.s_v});

        // startup: alarm outputs stay quiet until ready
        if (!q.ready) begin
          d.rdy_cnt = q.rdy_cnt + 8'h01;
          d.ready   = (d.rdy_cnt >= RDY_MAX);
        end

        // one control source at a time
        unique case (q.mode)
          M_INTERNAL: begin
            if (take) begin
              d.mode           = M_ANALOG;
              ev[IRQ_TAKEOVER] = 1'b1;
            end else if (dig) begin
              d.mode = M_DIGITAL;
            end
          end
          M_ANALOG: begin
            if (!take) begin
              d.mode           = M_INTERNAL;
              ev[IRQ_TAKEOVER] = 1'b1;
            end
            if (dig) begin
              ev[IRQ_REFUSED] = 1'b1;
            end
          end
          M_DIGITAL: begin
            if (!dig) begin
              d.mode = M_INTERNAL;
            end
            if (take) begin
              ev[IRQ_REFUSED] = 1'b1;
            end
          end
          default: d.mode = M_INTERNAL;
        endcase

        // set values follow the pins only under analog takeover
        if (q.mode == M_ANALOG) begin
          if (steady) begin
            d.set_v = quant(q.s_v, r5);
            d.set_i = quant(q.s_i, r5);
            d.set_p = quant(q.s_p, r5);
          end
          d.res_on = !q.s_res_n;
          if (!q.s_res_n && steady) begin
            d.set_r = quant(q.s_r, r5);
          end
        end else begin
          d.res_on = 1'b0;
        end

        // readback stays available in every mode
        d.mon_v = mon(actual_voltage, r5);
        d.mon_i = mon(actual_current, r5);

        // acknowledge: low phase counted in ticks, on rising edge
        if (!sb_on) begin
          if (q.low_cnt != 8'hFF) begin
            d.low_cnt = q.low_cnt + 8'h01;
          end
        end else begin
          ack = (q.low_cnt >= ACK_MIN) &&
                (q.mode == M_ANALOG);
          d.low_cnt = '0;
        end
        ev[IRQ_ACK] = ack;
      end

      // pending alarms: a present alarm always wins over ack
      ev[IRQ_ALARM] = |(alm & ~q.latch);
      d.latch = (q.latch & ~{5{ack}}) | alm;

      // input on/off: standby always gates, alarms force off
      if (q.eval) begin
        if (q.mode == M_ANALOG) begin
          d.dc_on = sb_on;
        end else begin
          d.dc_on = sb_on && manual_dc_on;
        end
      end
      if (|d.latch) begin
        d.dc_on = 1'b0;
      end

      // alarm pins carry the or of routed alarms only
      d.al1 = d.ready && |(d.latch & ~q.route);
      d.al2 = d.ready && |(d.latch & q.route);

      // sticky events: a new event beats a clear
      d.irq_st = (q.irq_st & ~w1c) | ev;
      d.irq    = |(d.irq_st & d.irq_mk);
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.ctrl    <= CTRL_RST;
      q.route   <= ROUTE_RST;
      q.irq_mk  <= IRQ_MK_RST;
      q.mode    <= M_INTERNAL;
      q.s_rem_n <= 1'b1;
      q.s_res_n <= 1'b1;
      q.s_sb    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign reg_rdata           = q.rdata;
  assign set_voltage         = q.set_v;
  assign set_current         = q.set_i;
  assign set_power           = q.set_p;
  assign set_resistance      = q.set_r;
  assign voltage_monitor_out = q.mon_v;
  assign current_monitor_out = q.mon_i;
  assign analog_active       = q.mode[1];
  assign resistance_mode     = q.res_on;
  assign dc_input_on         = q.dc_on;
  assign alarm1_out          = q.al1;
  assign alarm2_out          = q.al2;
  assign device_ready        = q.ready;
  assign irq                 = q.irq;

endmodule : analog_remote_interface_ctrl
`default_nettype wire

// ==== hw/arc_pkg.sv ====
// shared constants and types of the analog remote control logic
package arc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned SAMPLE_HZ    = 500;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned ACK_LOW_MS   = 50;
  // least time, so round up to whole ticks
  localparam int unsigned ACK_LOW_TICKS =
    (ACK_LOW_MS * SAMPLE_HZ + 999) / 1000;
  localparam int unsigned START_TICKS  = 10;

  // ---------------------------------------------------------------
  // converter scaling
  // ---------------------------------------------------------------
  localparam logic [15:0] STEPS_10V = 16'h6666;
  localparam logic [15:0] STEPS_5V  = STEPS_10V >> 1;

  // ---------------------------------------------------------------
  // synchronised pin vector layout
  // ---------------------------------------------------------------
  localparam int unsigned PIN_W      = 67;
  localparam int unsigned PIN_REM_N  = 0;
  localparam int unsigned PIN_RES_N  = 1;
  localparam int unsigned PIN_SB     = 2;
  localparam int unsigned PIN_VSET   = 3;
  localparam int unsigned PIN_ISET   = 19;
  localparam int unsigned PIN_PSET   = 35;
  localparam int unsigned PIN_RSET   = 51;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ROUTE  = 8'h04;
  localparam logic [7:0] REG_STATE  = 8'h08;
  localparam logic [7:0] REG_IRQ_ST = 8'h0C;
  localparam logic [7:0] REG_IRQ_MK = 8'h10;
  localparam logic [7:0] REG_SET_VI = 8'h14;
  localparam logic [7:0] REG_SET_PR = 8'h18;
  localparam logic [7:0] REG_MON    = 8'h1C;

  localparam int unsigned CTRL_RANGE5 = 0;
  localparam int unsigned CTRL_SBINV  = 1;
  localparam int unsigned CTRL_DIGREQ = 2;
  localparam logic [2:0]  CTRL_RST    = 3'h0;

  // alarm indices; a route bit of one sends the alarm to output 2
  localparam int unsigned ALM_OT = 0;
  localparam int unsigned ALM_PF = 1;
  localparam int unsigned ALM_OV = 2;
  localparam int unsigned ALM_OC = 3;
  localparam int unsigned ALM_OP = 4;
  localparam logic [4:0]  ROUTE_RST = 5'h1C;

  localparam int unsigned IRQ_TAKEOVER = 0;
  localparam int unsigned IRQ_ACK      = 1;
  localparam int unsigned IRQ_ALARM    = 2;
  localparam int unsigned IRQ_REFUSED  = 3;
  localparam logic [3:0]  IRQ_MK_RST   = 4'h0;

  typedef enum logic [2:0] {
    M_INTERNAL = 3'b001,
    M_ANALOG   = 3'b010,
    M_DIGITAL  = 3'b100
  } ctrl_mode_t;

endpackage : arc_pkg

// ==== hw/acq_if.sv ====
// sample tick and synchronised pin levels shared by the acquisition parts
`timescale 1ns/1ps
`default_nettype none
interface acq_if #(parameter int unsigned W = 67);
  logic         tick;
  logic [W-1:0] pins;
  modport tick_side (output tick);
  modport sync_side (output pins);
  modport core      (input tick, input pins);
endinterface : acq_if
`default_nettype wire

// ==== hw/pin_sync.sv ====
// two-stage synchroniser for all pins and converter codes
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import arc_pkg::*;
#(
  parameter int unsigned W = PIN_W
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  acq_if.sync_side          acq
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t st_q;
  sync_st_t st_d;

  // first stage is read by the second stage only
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign acq.pins = st_q.s2;
endmodule : pin_sync
`default_nettype wire

// ==== hw/tick_gen.sv ====
// divider producing the one-cycle acquisition tick
`timescale 1ns/1ps
`default_nettype none
module tick_gen
  import arc_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  acq_if.tick_side  acq
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } tick_st_t;

  tick_st_t st_q;
  tick_st_t st_d;

  // free-running count, tick is a registered pulse
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.tick = (st_q.cnt == LAST);
      st_d.cnt  = st_d.tick ? '0 : st_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign acq.tick = st_q.tick;
endmodule : tick_gen
`default_nettype wire

// ==== verification/arc_monitor.sv ====
// assertion checker for the analog remote control block
`timescale 1ns/1ps
`default_nettype none
module arc_monitor
  import arc_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        overtemperature_alarm,
  input wire logic        supply_failure_alarm,
  input wire logic        overvoltage_alarm,
  input wire logic        overcurrent_alarm,
  input wire logic        overpower_alarm,
  input wire logic [15:0] set_voltage,
  input wire logic        analog_active,
  input wire logic        dc_input_on,
  input wire logic        alarm1_out,
  input wire logic        alarm2_out,
  input wire logic        device_ready
);
  logic [4:0]  alm;
  logic [4:0]  route_q;
  logic        act_q;
  logic [31:0] gap_q;
  assign alm = {overpower_alarm, overcurrent_alarm, overvoltage_alarm,
                supply_failure_alarm, overtemperature_alarm};
  // ---
  // shadow of the routing register and cycles since analog_active last changed
  // ---
  // gap starts saturated so the first takeover after reset never fires
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      route_q <= ROUTE_RST;
      act_q   <= 1'b0;
      gap_q   <= TICK_CYC;
    end else begin
      if (reg_wr && reg_addr == REG_ROUTE) route_q <= reg_wdata[4:0];
      act_q <= analog_active;
      if (analog_active != act_q) gap_q <= 32'h1;
      else if (gap_q < TICK_CYC) gap_q <= gap_q + 32'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_alarm_drops_dc: assert property (analog_active && |alm |=> !dc_input_on)
    else $error("dc input stayed on during an alarm");
  a_set_ignored: assert property (!analog_active ##1 !analog_active |-> $stable(set_voltage))
    else $error("set value moved without takeover");
  a_full_scale: assert property (set_voltage <= STEPS_10V)
    else $error("set value above full scale");
  a_route_first: assert property (device_ready && |(alm & ~route_q) |-> ##[1:2] alarm1_out)
    else $error("first alarm output missed its alarm");
  a_route_second: assert property (device_ready && |(alm & route_q) |-> ##[1:2] alarm2_out)
    else $error("second alarm output missed its alarm");
  a_ready_first: assert property (alarm1_out || alarm2_out |-> device_ready)
    else $error("alarm output before ready");
  a_mode_rate: assert property (analog_active != act_q |-> gap_q >= TICK_CYC)
    else $error("mode changed faster than the sample rate");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : arc_monitor
bind analog_remote_interface_ctrl arc_monitor #(.TICK_CYC(TICK_CYC)) mon_u (
  .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .overtemperature_alarm, .supply_failure_alarm, .overvoltage_alarm,
  .overcurrent_alarm, .overpower_alarm, .set_voltage, .analog_active,
  .dc_input_on, .alarm1_out, .alarm2_out, .device_ready);
`default_nettype wire

// ==== verification/arc_partner.sv ====
// model of the external controller driving the analog port
`timescale 1ns/1ps
`default_nettype none
module arc_partner
  import arc_pkg::*;
#(
  parameter int unsigned LOW_CYC = 100
) (
  input  wire logic        ref_clk,
  input  wire logic        want_remote,
  input  wire logic        want_res,
  input  wire logic        want_on,
  input  wire logic        ack_go,
  input  wire logic [15:0] v_code,
  output logic             takeover_n_pin,
  output logic             res_mode_n_pin,
  output logic             input_standby_ctrl,
  output logic      [15:0] voltage_setpoint_in,
  output logic      [15:0] current_setpoint_in,
  output logic      [15:0] power_setpoint_in,
  output logic      [15:0] resistance_setpoint_in
);
  int unsigned low_cnt = 0;
  // ---
  // pins: contacts to ground, released pins read high
  // ---
  assign takeover_n_pin = !want_remote;
  assign res_mode_n_pin = !want_res;
  // low phase outlasts the acknowledge time with margin
  assign input_standby_ctrl = want_on && (low_cnt == 0);
  // unused set inputs are strapped to the reference so they read full scale
  assign voltage_setpoint_in = v_code;
  assign current_setpoint_in = STEPS_10V;
  assign power_setpoint_in = STEPS_10V;
  assign resistance_setpoint_in = v_code;
  // alarm outputs are not read by this model, so startup noise is ignored
  always @(posedge ref_clk) begin
    if (ack_go) low_cnt <= LOW_CYC;
    else if (low_cnt != 0) low_cnt <= low_cnt - 1;
  end
endmodule : arc_partner
`default_nettype wire

// ==== verification/analog_remote_interface_ctrl_tb.sv ====
// self-checking bench of the analog remote control block
`timescale 1ns/1ps
`default_nettype none
module analog_remote_interface_ctrl_tb
  import arc_pkg::*;
;
  localparam int unsigned TICK = 20;
  localparam int unsigned ACK = 3;
  logic ref_clk = 1'b0;
  logic rst_n, clk_en, reg_wr, reg_rd, manual_dc_on, ack_go;
  logic overtemperature_alarm, supply_failure_alarm, overvoltage_alarm;
  logic overcurrent_alarm, overpower_alarm, want_remote, want_res, want_on;
  logic takeover_n_pin, res_mode_n_pin, input_standby_ctrl, irq;
  logic analog_active, resistance_mode, dc_input_on, alarm1_out;
  logic alarm2_out, device_ready;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_q;
  logic [15:0] actual_voltage, actual_current, v_code, set_voltage;
  logic [15:0] voltage_setpoint_in, current_setpoint_in, power_setpoint_in;
  logic [15:0] resistance_setpoint_in, set_current, set_power;
  logic [15:0] set_resistance, voltage_monitor_out, current_monitor_out;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  analog_remote_interface_ctrl #(.TICK_CYC(TICK), .ACK_TICKS(ACK),
    .RDY_TICKS(2)) dut_u (.ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .takeover_n_pin, .res_mode_n_pin,
    .input_standby_ctrl, .voltage_setpoint_in, .current_setpoint_in,
    .power_setpoint_in, .resistance_setpoint_in, .overtemperature_alarm,
    .supply_failure_alarm, .overvoltage_alarm, .overcurrent_alarm,
    .overpower_alarm, .actual_voltage, .actual_current, .manual_dc_on,
    .set_voltage, .set_current, .set_power, .set_resistance,
    .voltage_monitor_out, .current_monitor_out, .analog_active,
    .resistance_mode, .dc_input_on, .alarm1_out, .alarm2_out, .device_ready,
    .irq);
  arc_partner #(.LOW_CYC((ACK + 2) * TICK)) partner_u (.ref_clk,
    .want_remote, .want_res, .want_on, .ack_go, .v_code, .takeover_n_pin,
    .res_mode_n_pin, .input_standby_ctrl, .voltage_setpoint_in,
    .current_setpoint_in, .power_setpoint_in, .resistance_setpoint_in);
  // ---
  // clock, hang guard and shared tasks
  // ---
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // strobes drop for a cycle so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_q = reg_rdata;
    @(posedge ref_clk);
  endtask : rd
  // pin to output latency is at most one tick plus four cycles
  task automatic evals(input int n);
    repeat (n * TICK + 6) @(posedge ref_clk);
  endtask : evals
  task automatic t_reset();
    chk(device_ready, 1'b0);
    rd(REG_CTRL);
    chk(rd_q, {29'h0, CTRL_RST});
    rd(REG_ROUTE);
    chk(rd_q, {27'h0, ROUTE_RST});
    rd(8'h40);
    chk(rd_q, 32'h0);
    evals(3);
    chk(device_ready, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_manual();
    v_code <= 16'h1234;
    manual_dc_on <= 1'b1;
    evals(2);
    chk(analog_active, 1'b0);
    chk(set_voltage, 16'h0000);
    chk(dc_input_on, 1'b1);
    want_on <= 1'b0;
    evals(1);
    chk(dc_input_on, 1'b0);
    wr(REG_CTRL, 32'h2);
    evals(1);
    chk(dc_input_on, 1'b1);
    wr(REG_CTRL, 32'h0);
    want_on <= 1'b1;
    $display("test manual done");
  endtask : t_manual
  task automatic t_analog();
    manual_dc_on <= 1'b0;
    want_remote <= 1'b1;
    actual_current <= 16'h0123;
    // set values follow from the evaluation after takeover
    evals(2);
    chk(analog_active, 1'b1);
    chk(set_voltage, 16'h1234);
    chk(set_current, STEPS_10V);
    chk(set_power, STEPS_10V);
    chk(current_monitor_out, 16'h0123);
    chk(dc_input_on, 1'b1);
    v_code <= 16'hFFFF;
    want_res <= 1'b1;
    evals(2);
    chk(set_voltage, STEPS_10V);
    chk(resistance_mode, 1'b1);
    chk(set_resistance, STEPS_10V);
    wr(REG_CTRL, 32'h1);
    v_code <= 16'h1000;
    actual_voltage <= 16'h2000;
    evals(1);
    chk(set_voltage, 16'h2000);
    chk(voltage_monitor_out, 16'h1000);
    rd(REG_SET_VI);
    chk(rd_q, {STEPS_10V, 16'h2000});
    v_code <= 16'h3334;
    evals(1);
    chk(set_voltage, STEPS_10V);
    wr(REG_CTRL, 32'h0);
    $display("test analog done");
  endtask : t_analog
  task automatic t_excl();
    wr(REG_IRQ_ST, 32'hF);
    wr(REG_CTRL, 32'h4);
    evals(1);
    rd(REG_STATE);
    chk(rd_q[2:0], M_ANALOG);
    rd(REG_IRQ_ST);
    chk(rd_q[IRQ_REFUSED], 1'b1);
    wr(REG_CTRL, 32'h0);
    wr(REG_IRQ_ST, 32'hF);
    $display("test exclusive done");
  endtask : t_excl
  task automatic t_alarm();
    wr(REG_IRQ_MK, 32'h4);
    {overtemperature_alarm, overvoltage_alarm} <= 2'b11;
    repeat (3) @(posedge ref_clk);
    chk(dc_input_on, 1'b0);
    chk({alarm2_out, alarm1_out}, 2'b11);
    chk(irq, 1'b1);
    {overtemperature_alarm, overvoltage_alarm} <= 2'b00;
    evals(1);
    chk(alarm1_out, 1'b1);
    ack_go <= 1'b1;
    @(posedge ref_clk);
    ack_go <= 1'b0;
    evals(ACK + 4);
    chk({alarm2_out, alarm1_out}, 2'b00);
    chk(dc_input_on, 1'b1);
    wr(REG_IRQ_ST, 32'h4);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    wr(REG_ROUTE, 32'h1);
    overtemperature_alarm <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({alarm2_out, alarm1_out}, 2'b10);
    overtemperature_alarm <= 1'b0;
    $display("test alarm done");
  endtask : t_alarm
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // ---
  // main sequence
  // ---
  initial begin
    {rst_n, reg_wr, reg_rd, manual_dc_on, ack_go, want_remote} = '0;
    {overtemperature_alarm, supply_failure_alarm, overvoltage_alarm} = '0;
    {overcurrent_alarm, overpower_alarm, want_res} = '0;
    {clk_en, want_on} = 2'b11;
    {reg_addr, reg_wdata, v_code} = '0;
    {actual_voltage, actual_current} = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_manual();
    t_analog();
    t_excl();
    t_alarm();
    complete_run();
  end
endmodule : analog_remote_interface_ctrl_tb
`default_nettype wire
